// ===== io_instruction_unit.sv
// io_instruction_unit: executes i/o instructions written over ahb-lite
// assumes one 250 MHz clock; port pins and led_mode are asynchronous
// Notes on behaviour
// - working register n lives at data memory address n plus 70h.
// - index pointer is 8 bits; high and low nibbles loaded separately.
// - pixel latch addresses 00h to 1fh for every latch load.
// - decoded load passes source through decoder; blanking variant zeroes on 0.
// - decoded and blanking loads may take the indexed ram word.
// - direct load stores source nibble plus accumulator nibble undecoded.
// - table load copies the rom word at the index pointer.
// - ports a, b: x bit n makes pin n+1 output; x4 enables pulls.
// - pull-low acts only on pins set as inputs.
// - port c: x4=1 pulls on, hold off; x4=0 the reverse.
// - port writes drive the memory nibble onto the port latches.
// - pulse write: pins 1,2 from memory, pin 3 from d, pin 4 pulses.
// - port reads store pins into accumulator and memory word.
// - key scan drives one output, all sixteen, or none.
// - active scan level is high in led mode, low in lcd mode.
// - x6 selects normal scanning or scanning-cycle halt release.
// - scan outputs appear only during the scanning interval.
// - buzzer carrier chosen by x8..x6; pins complementary.
// - x5..x0 enable 1 Hz to 32 Hz envelope taps.
// - tone taps come from the 32768 Hz prescaler chain, except carrier x8..x6=111, which takes gen_out_a.
// - el pump clock from x8..x6, duty from x5,x4.
// - direct load: source on bus a..d, accumulator on e..h; table a..h.
// - el discharge tap from x3,x2, duty from x1,x0.
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
module io_instruction_unit
  import io_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // table rom
  output logic [7:0]       table_rom_addr,
  input  wire logic [7:0]  table_rom_word,
  // display side
  input  wire logic        led_mode,
  input  wire logic        scan_interval,
  output logic [7:0]       display_data_bus,
  output logic [4:0]       pixel_latch_addr,
  output logic             latch_strobe,
  // ports
  input  wire logic [3:0]  port_a_in,
  input  wire logic [3:0]  port_b_in,
  input  wire logic [3:0]  port_c_in,
  output port_drive_t      port_a_drv,
  output port_drive_t      port_b_drv,
  output port_drive_t      port_c_drv,
  output logic [3:0]       port_c_hold_en,
  // key scan
  output logic [15:0]      scan_outputs,
  output logic [15:0]      scan_oe,
  output logic             scan_cycle_mode,
  // buzzer and el
  input  wire logic        gen_out_a,
  input  wire logic        bclk_in,
  output logic             buzzer_out,
  output logic             buzzer_out_inv,
  output logic             el_pump_pin,
  output logic             el_control
);
  logic [3:0]  ram_r [128];
  logic [7:0]  latch_r [32];
  logic [11:0] addr_r;
  logic        wr_r, rd_wait_r, acc_ph, ex;
  logic [31:0] rdata_r, rmux;
  instr_t      ins;
  logic [3:0]  acc_r, src, mem_word;
  logic [7:0]  index_r;
  logic [11:0] pin_s1_r, pin_s2_r;
  logic [1:0]  led_s_r;
  logic [3:0]  pa_out_r, pb_out_r, pc_out_r, pa_dir_r, pb_dir_r, pc_dir_r;
  logic        pa_pull_r, pb_pull_r, pc_pull_r, pulse_r;
  logic [15:0] key_oe_r;
  logic [8:0]  tone_x_r, el_x_r;

  function automatic logic [6:0] wreg_addr(input logic [3:0] n);
    return WREG_BASE | {3'b000, n};
  endfunction

  // seven-segment style digit decoder, segment a on bit 0
  function automatic logic [7:0] digit_decode(input logic [3:0] n);
    case (n)
      4'h0: return 8'h3f;  4'h1: return 8'h06;  4'h2: return 8'h5b;  4'h3: return 8'h4f;
      4'h4: return 8'h66;  4'h5: return 8'h6d;  4'h6: return 8'h7d;  4'h7: return 8'h07;
      4'h8: return 8'h7f;  4'h9: return 8'h6f;  4'ha: return 8'h77;  4'hb: return 8'h7c;
      4'hc: return 8'h39;  4'hd: return 8'h5e;  4'he: return 8'h79;  default: return 8'h71;
    endcase
  endfunction

  // one-hot, all or none; every other pattern floats all outputs
  function automatic logic [15:0] scan_decode(input logic [5:0] x);
    if (x[5:4] == 2'b00) return 16'h0001 << x[3:0];
    if (x == 6'h10) return 16'hffff;
    return 16'h0000;
  endfunction

  // bus slave: writes take no wait, reads one wait so a write just before
  // a read of the same word is always seen
  assign acc_ph    = hsel && htrans[1] && hready;
  assign hreadyout = !rd_wait_r;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;
  assign ins       = instr_t'(hwdata);
  assign ex        = wr_r && addr_r == OFS_INSTR;
  assign mem_word  = ram_r[ins.addr];
  assign src       = ins.use_index ? ram_r[index_r[6:0]] : ram_r[wreg_addr(ins.work_reg_num)];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_r      <= 1'b0;
      rd_wait_r <= 1'b0;
      addr_r    <= 12'h000;
      rdata_r   <= 32'h0000_0000;
    end else begin
      if (hready) begin
        wr_r      <= acc_ph && hwrite;
        rd_wait_r <= acc_ph && !hwrite;
        if (acc_ph) addr_r <= haddr[11:0];
      end else begin
        rd_wait_r <= 1'b0;
      end
      if (rd_wait_r) rdata_r <= rmux;
    end
  end

  always_comb begin
    rmux = RD_UNMAPPED;
    if (addr_r[11:9] == RAM_WIN) rmux = {28'h0, ram_r[addr_r[8:2]]};
    else if (addr_r[11:7] == LATCH_WIN) rmux = {24'h0, latch_r[addr_r[6:2]]};
    else if (addr_r == OFS_STATUS) rmux = {18'h0, led_s_r[1], scan_cycle_mode, index_r, acc_r};
    else if (addr_r == OFS_PORTS)
      rmux = {5'h00, pc_pull_r, pb_pull_r, pa_pull_r, pin_s2_r, pc_dir_r, pb_dir_r, pa_dir_r};
  end

  // data memory: bus window writes and port reads
  always_ff @(posedge clock) begin
    if (wr_r && addr_r[11:9] == RAM_WIN) ram_r[addr_r[8:2]] <= hwdata[3:0];
    if (ex) begin
      case (ins.op)
        PORT_A_READ: ram_r[ins.addr] <= pin_s2_r[3:0];
        PORT_B_READ: ram_r[ins.addr] <= pin_s2_r[7:4];
        PORT_C_READ: ram_r[ins.addr] <= pin_s2_r[11:8];
        default: ;
      endcase
    end
  end

  // pins are asynchronous: two flops before anything reads them
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 12'h000;
      pin_s2_r <= 12'h000;
      led_s_r  <= 2'b00;
    end else begin
      pin_s1_r <= {port_c_in, port_b_in, port_a_in};
      pin_s2_r <= pin_s1_r;
      led_s_r  <= {led_s_r[0], led_mode};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_r   <= 4'h0;
      index_r <= 8'h00;
    end else if (ex) begin
      case (ins.op)
        LOAD_INDEX_HIGH: index_r[7:4] <= mem_word;
        LOAD_INDEX_LOW:  index_r[3:0] <= mem_word;
        PORT_A_READ:     acc_r <= pin_s2_r[3:0];
        PORT_B_READ:     acc_r <= pin_s2_r[7:4];
        PORT_C_READ:     acc_r <= pin_s2_r[11:8];
        default: ;
      endcase
    end
  end
  assign table_rom_addr = index_r;

  // pixel latch loads
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      display_data_bus <= 8'h00;
      pixel_latch_addr <= 5'h00;
      latch_strobe     <= 1'b0;
    end else begin
      latch_strobe <= 1'b0;
      if (ex && ins.op <= LATCH_LOAD_TABLE) begin
        latch_strobe     <= 1'b1;
        pixel_latch_addr <= ins.addr[4:0];
        case (ins.op)
          LATCH_LOAD_DECODED:  display_data_bus <= digit_decode(src);
          LATCH_LOAD_BLANKING: display_data_bus <= (src == 4'h0) ? 8'h00 : digit_decode(src);
          LATCH_LOAD_DIRECT:   display_data_bus <= {acc_r, src};
          default:             display_data_bus <= table_rom_word;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (latch_strobe) latch_r[pixel_latch_addr] <= display_data_bus;
  end

  // port a carries the pulse write; pin 4 falls one cycle after it rises
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pa_out_r  <= 4'h0;
      pa_dir_r  <= 4'h0;
      pa_pull_r <= 1'b0;
      pulse_r   <= 1'b0;
    end else begin
      pulse_r <= ex && ins.op == PORT_A_WRITE_PULSE;
      if (pulse_r) pa_out_r[3] <= 1'b0;
      if (ex) begin
        case (ins.op)
          PORT_A_SETUP: begin
            pa_dir_r  <= ins.x[3:0];
            pa_pull_r <= ins.x[4];
          end
          PORT_A_WRITE:       pa_out_r <= mem_word;
          PORT_A_WRITE_PULSE: pa_out_r <= {1'b1, ins.x[0], mem_word[1:0]};
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pb_out_r  <= 4'h0;
      pb_dir_r  <= 4'h0;
      pb_pull_r <= 1'b0;
      pc_out_r  <= 4'h0;
      pc_dir_r  <= 4'h0;
      pc_pull_r <= 1'b0;
    end else if (ex) begin
      case (ins.op)
        PORT_B_SETUP: begin
          pb_dir_r  <= ins.x[3:0];
          pb_pull_r <= ins.x[4];
        end
        PORT_C_SETUP: begin
          pc_dir_r  <= ins.x[3:0];
          pc_pull_r <= ins.x[4];
        end
        PORT_B_WRITE: pb_out_r <= mem_word;
        PORT_C_WRITE: pc_out_r <= mem_word;
        default: ;
      endcase
    end
  end

  assign port_a_drv     = '{out: pa_out_r, oe: pa_dir_r, pull_en: {4{pa_pull_r}} & ~pa_dir_r};
  assign port_b_drv     = '{out: pb_out_r, oe: pb_dir_r, pull_en: {4{pb_pull_r}} & ~pb_dir_r};
  assign port_c_drv     = '{out: pc_out_r, oe: pc_dir_r, pull_en: {4{pc_pull_r}} & ~pc_dir_r};
  assign port_c_hold_en = {4{~pc_pull_r}} & ~pc_dir_r;

  // key scan and tone/el operand registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      key_oe_r        <= 16'h0000;
      scan_cycle_mode <= 1'b0;
      tone_x_r        <= 9'h000;
      el_x_r          <= 9'h000;
    end else if (ex) begin
      case (ins.op)
        KEY_SCAN_SET: begin
          key_oe_r        <= scan_decode(ins.x[5:0]);
          scan_cycle_mode <= ins.x[6];
        end
        BUZZER_SELECT: tone_x_r <= ins.x;
        EL_SET:        el_x_r   <= ins.x;
        default: ;
      endcase
    end
  end

  // segment pins belong to the display outside the scanning interval
  assign scan_oe      = scan_interval ? key_oe_r : 16'h0000;
  assign scan_outputs = {16{led_s_r[1]}};

  tone_pump_gen u_tone (
    .clock          (clock),
    .rst_n          (rst_n),
    .tone_x         (tone_x_r),
    .el_x           (el_x_r),
    .gen_out_a      (gen_out_a),
    .bclk_in        (bclk_in),
    .buzzer_out     (buzzer_out),
    .buzzer_out_inv (buzzer_out_inv),
    .el_pump_pin    (el_pump_pin),
    .el_control     (el_control)
  );

  a_latch_addr: assert property (@(posedge clock) disable iff (!rst_n)
    ex && ins.op == LATCH_LOAD_TABLE |=> latch_strobe && pixel_latch_addr == $past(ins.addr[4:0]))
    else $error("latch address not taken");
  a_blank_zero: assert property (@(posedge clock) disable iff (!rst_n)
    ex && ins.op == LATCH_LOAD_BLANKING && src == 4'h0 |=> display_data_bus == 8'h00)
    else $error("blanking did not zero bus");
  a_direct_bus: assert property (@(posedge clock) disable iff (!rst_n)
    ex && ins.op == LATCH_LOAD_DIRECT |=> display_data_bus == {$past(acc_r), $past(src)})
    else $error("direct load bus mismatch");
  a_table_bus: assert property (@(posedge clock) disable iff (!rst_n)
    ex && ins.op == LATCH_LOAD_TABLE |=> display_data_bus == $past(table_rom_word))
    else $error("table load bus mismatch");
  a_index_high: assert property (@(posedge clock) disable iff (!rst_n)
    ex && ins.op == LOAD_INDEX_HIGH |=> index_r[7:4] == $past(mem_word))
    else $error("index high nibble not loaded");
  a_pull_input: assert property (@(posedge clock) disable iff (!rst_n)
    (port_a_drv.pull_en & port_a_drv.oe) == 4'h0) else $error("pull on output pin");
  a_hold_pull: assert property (@(posedge clock) disable iff (!rst_n)
    (port_c_hold_en & port_c_drv.pull_en) == 4'h0) else $error("hold and pull together");
  a_pulse_one: assert property (@(posedge clock) disable iff (!rst_n)
    ex && ins.op == PORT_A_WRITE_PULSE ##1 !ex |-> port_a_drv.out[3] ##1 !port_a_drv.out[3])
    else $error("pin 4 pulse not one cycle");
  a_port_read: assert property (@(posedge clock) disable iff (!rst_n)
    ex && ins.op == PORT_B_READ |=> acc_r == $past(pin_s2_r[7:4]))
    else $error("port read not in accumulator");
  a_scan_shape: assert property (@(posedge clock) disable iff (!rst_n)
    $onehot0(key_oe_r) || key_oe_r == 16'hffff) else $error("scan pattern illegal");
  a_scan_gate: assert property (@(posedge clock) disable iff (!rst_n)
    !scan_interval |-> scan_oe == 16'h0000) else $error("scan outside interval");

  c_table_load: cover property (@(posedge clock) disable iff (!rst_n)
    ex && ins.op == LATCH_LOAD_TABLE);
  c_pulse_write: cover property (@(posedge clock) disable iff (!rst_n)
    ex && ins.op == PORT_A_WRITE_PULSE);
  c_scan_active: cover property (@(posedge clock) disable iff (!rst_n)
    scan_interval && scan_oe != 16'h0000);
endmodule // io_instruction_unit

// ===== io_instruction_unit_tb_top.sv
// io_instruction_unit_tb_top: self-checking bench for the i/o instruction unit
// assumes this bench is the only ahb-lite master; pin_partner stands at the pins
`timescale 1ns/1ns
`define CHK(gv, ev) begin check_count++; if ((gv) !== (ev)) begin num_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, gv, ev); end end
module io_instruction_unit_tb_top
  import io_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        led_mode = 1'b1;
  logic        scan_interval = 1'b0;
  logic        rd_wait = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [11:0] ext_val = 12'h0;
  logic [31:0] hrdata, ex;
  logic [11:0] pins;
  logic [7:0]  table_rom_addr, table_rom_word, display_data_bus;
  logic [4:0]  pixel_latch_addr;
  logic [15:0] scan_outputs, scan_oe;
  logic [3:0]  port_c_hold_en;
  logic        hreadyout, hresp, latch_strobe, scan_cycle_mode, gen_out_a, bclk_in;
  logic        buzzer_out, buzzer_out_inv, el_pump_pin, el_control;
  port_drive_t drv [3];
  logic [31:0] exp_q [$];
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  op_t         opw [3] = '{PORT_A_WRITE, PORT_B_WRITE, PORT_C_WRITE};
  logic [8:0]  bx [5] = '{9'h100, 9'h000, 9'h140, 9'h101, 9'h100};
  logic [4:0]  bexp = 5'b10001;
  logic [7:0]  seg [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
                            8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};

  io_instruction_unit DUT (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .table_rom_addr,
    .table_rom_word, .led_mode, .scan_interval, .display_data_bus, .pixel_latch_addr,
    .latch_strobe, .port_a_in(pins[3:0]), .port_b_in(pins[7:4]), .port_c_in(pins[11:8]),
    .port_a_drv(drv[0]), .port_b_drv(drv[1]), .port_c_drv(drv[2]), .port_c_hold_en,
    .scan_outputs, .scan_oe, .scan_cycle_mode, .gen_out_a, .bclk_in, .buzzer_out,
    .buzzer_out_inv, .el_pump_pin, .el_control);
  pin_partner partner (.clock, .drv_a(drv[0]), .drv_b(drv[1]), .drv_c(drv[2]),
    .rom_addr(table_rom_addr), .ext_val, .pins, .rom_word(table_rom_word),
    .gen_a(gen_out_a), .bclk(bclk_in));

  initial forever #2 clock = ~clock;

  // entered just after a rising edge; ready is sampled at each rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    rd_wait <= ~w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd_wait <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic exe(input op_t op, input logic [8:0] x, input logic [6:0] ad,
                     input logic [3:0] wn, input logic ui);
    instr_t i = '{wn, ui, ad, 3'h0, x, 3'h0, op};
    wr({20'h0, OFS_INSTR}, i);
  endtask
  function automatic logic [31:0] ram(input logic [6:0] a);
    return {20'h0, RAM_WIN, a, 2'b00};
  endfunction
  function automatic logic [31:0] lat(input logic [4:0] z);
    return {20'h0, LATCH_WIN, z, 2'b00};
  endfunction
  // status before any key scan: led mode high, scan-cycle mode low
  function automatic logic [31:0] st(input logic [7:0] ix, input logic [3:0] acc);
    return {18'h0, 2'b10, ix, acc};
  endfunction

  // read data is taken at the rising edge that completes the data phase
  always @(posedge clock) begin
    if (rd_wait === 1'b1 && hreadyout === 1'b1) begin
      ex = exp_q.pop_front();
      `CHK({hresp, hrdata}, {1'b0, ex})
    end
  end

  task automatic print_verdict;
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict;
    end
  end

  initial begin : main
    logic [3:0]  v, p, h, l, cnt;
    logic [8:0]  x;
    logic [15:0] k;
    logic        g;
    void'($urandom(10475));
    ext_val <= 12'($urandom);
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    `CHK({port_c_hold_en, buzzer_out_inv}, 5'h1f)
    rd(32'h4, st(8'h0, 4'h0));
    rd({20'h0, OFS_PORTS}, {8'h0, ext_val, 12'h0});
    for (int i = 0; i < 3; i++) begin
      x = 9'($urandom_range(0, 31));
      v = 4'($urandom);
      wr(ram(7'h10 + 7'(i)), {28'h0, v});
      exe(op_t'(int'(PORT_A_SETUP) + i), x, 7'h0, 4'h0, 1'b0);
      exe(opw[i], 9'h0, 7'h10 + 7'(i), 4'h0, 1'b0);
      @(negedge clock);
      `CHK({drv[i].out, drv[i].oe}, {v, x[3:0]})
      `CHK(drv[i].pull_en, x[4] ? ~x[3:0] : 4'h0)
      if (i == 2) `CHK(port_c_hold_en, x[4] ? 4'h0 : ~x[3:0])
      p = (v & x[3:0]) | (ext_val[4*i +: 4] & ~x[3:0]);
      repeat (3) @(posedge clock);
      exe(op_t'(int'(PORT_A_READ) + i), 9'h0, 7'h20 + 7'(i), 4'h0, 1'b0);
      rd(ram(7'h20 + 7'(i)), {28'h0, p});
      rd(32'h4, st(8'h0, p));
    end
    v = 4'($urandom);
    wr(ram(7'h75), {28'h0, v});
    exe(LATCH_LOAD_DIRECT, 9'h0, 7'h1f, 4'h5, 1'b0);
    @(negedge clock);
    `CHK({latch_strobe, pixel_latch_addr, display_data_bus}, {6'h3f, p, v})
    @(posedge clock);
    rd(lat(5'h1f), {24'h0, p, v});
    for (int n = 0; n < 16; n++) begin
      wr(ram(7'h70 + 7'(n)), 32'(n));
      exe(LATCH_LOAD_DECODED, 9'h0, 7'(n), 4'(n), 1'b0);
      exe(LATCH_LOAD_BLANKING, 9'h0, 7'(n + 16), 4'(n), 1'b0);
      rd(lat(5'(n)), {24'h0, seg[n]});
      rd(lat(5'(n + 16)), {24'h0, n == 0 ? 8'h0 : seg[n]});
    end
    h = 4'($urandom);
    l = 4'($urandom);
    wr(ram(7'h30), {28'h0, h});
    wr(ram(7'h31), {28'h0, l});
    exe(LOAD_INDEX_HIGH, 9'h0, 7'h30, 4'h0, 1'b0);
    exe(LOAD_INDEX_LOW, 9'h0, 7'h31, 4'h0, 1'b0);
    exe(LATCH_LOAD_TABLE, 9'h0, 7'h0e, 4'h0, 1'b0);
    `CHK(table_rom_addr, {h, l})
    rd(lat(5'h0e), {24'h0, {l, h} ^ 8'h3c});
    rd(32'h4, st({h, l}, p));
    wr(ram({h[2:0], l}), 32'h0);
    exe(LATCH_LOAD_BLANKING, 9'h0, 7'h0d, 4'h0, 1'b1);
    rd(lat(5'h0d), 32'h0);
    wr(ram({h[2:0], l}), 32'h7);
    exe(LATCH_LOAD_DECODED, 9'h0, 7'h0d, 4'h0, 1'b1);
    rd(lat(5'h0d), {24'h0, seg[7]});
    wr(ram(7'h40), {28'h0, v});
    exe(PORT_A_WRITE_PULSE, 9'h1, 7'h40, 4'h0, 1'b0);
    cnt = 4'h0;
    repeat (6) begin
      @(negedge clock);
      cnt += {3'b0, drv[0].out[3]};
    end
    `CHK({cnt, drv[0].out[2:0]}, {4'h1, 1'b1, v[1:0]})
    for (int i = 0; i < 19; i++) begin
      @(posedge clock);
      x = {2'b00, i[0], i < 16 ? 6'(i) : i == 16 ? 6'h10 : i == 17 ? 6'h20 : 6'h3f};
      k = i < 16 ? 16'(1 << i) : i == 16 ? 16'hffff : 16'h0;
      led_mode <= i[1];
      scan_interval <= (i != 5);
      exe(KEY_SCAN_SET, x, 7'h0, 4'h0, 1'b0);
      @(negedge clock);
      `CHK(scan_oe, i == 5 ? 16'h0 : k)
      `CHK({scan_cycle_mode, scan_outputs}, {i[0], {16{i[1]}}})
    end
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      // envelope bits are cleared again whenever no envelope is wanted
      exe(BUZZER_SELECT, bx[i], 7'h0, 4'h0, 1'b0);
      repeat (2) @(negedge clock);
      `CHK({buzzer_out, buzzer_out_inv}, {bexp[i], ~bexp[i]})
    end
    @(posedge clock);
    exe(BUZZER_SELECT, 9'h1c0, 7'h0, 4'h0, 1'b0);
    @(negedge clock);
    repeat (8) begin
      g = gen_out_a;
      @(negedge clock);
      `CHK(buzzer_out, g)
    end
    // an unlisted pump code first: the pin must stay low
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      exe(EL_SET, i ? 9'h130 : 9'h080, 7'h0, 4'h0, 1'b0);
      @(negedge clock);
      g = 1'b0;
      repeat (64) begin
        @(negedge clock);
        g |= el_pump_pin;
      end
      `CHK({g, el_control}, {1'(i), 1'b0})
    end
    print_verdict;
  end
endmodule // io_instruction_unit_tb_top

// ===== io_pkg.sv
// io_pkg: constants, opcodes and carrier types of the i/o instruction unit
// assumes a 250 MHz core clock and a 32768 Hz prescaler base rate
package io_pkg;
  localparam int unsigned CLK_HZ  = 250_000_000;
  localparam int unsigned BASE_HZ = 32768;
  // the prescaler steps twice per base period, so counter bit n is tap n
  localparam int unsigned PRE_CYC = CLK_HZ / (2 * BASE_HZ);
  localparam logic [6:0]  WREG_BASE = 7'h70;
  // register map (byte addresses, low 12 address bits decoded)
  localparam logic [11:0] OFS_INSTR  = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_PORTS  = 12'h008;
  localparam logic [4:0]  LATCH_WIN  = 5'h02;   // haddr[11:7], 0x100..0x17c
  localparam logic [2:0]  RAM_WIN    = 3'h1;    // haddr[11:9], 0x200..0x3fc
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  typedef enum logic [4:0] {
    LATCH_LOAD_DECODED, LATCH_LOAD_BLANKING, LATCH_LOAD_DIRECT, LATCH_LOAD_TABLE,
    LOAD_INDEX_HIGH, LOAD_INDEX_LOW, PORT_A_SETUP, PORT_B_SETUP, PORT_C_SETUP,
    PORT_A_WRITE, PORT_A_WRITE_PULSE, PORT_B_WRITE, PORT_C_WRITE,
    PORT_A_READ, PORT_B_READ, PORT_C_READ, KEY_SCAN_SET, BUZZER_SELECT, EL_SET
  } op_t;

  // instruction word written to OFS_INSTR
  typedef struct packed {
    logic [3:0] work_reg_num;  // [31:28]
    logic       use_index;     // [27] source is indexed_ram_word
    logic [6:0] addr;          // [26:20] memory address or pixel_latch_addr
    logic [2:0] rsv1;
    logic [8:0] x;             // [16:8] operand, x[0] is the immediate d
    logic [2:0] rsv0;
    op_t        op;            // [4:0]
  } instr_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
    logic [3:0] pull_en;
  } port_drive_t;
endpackage

// ===== pin_partner.sv
// pin_partner: port pins, table rom, tone source and pump clock beside the unit
// assumes the bench clock; the bench drives every pin the unit leaves as input
`timescale 1ns/1ns
module pin_partner
  import io_pkg::*;
(
  // clock
  input  wire logic        clock,
  // unit side
  input  port_drive_t      drv_a,
  input  port_drive_t      drv_b,
  input  port_drive_t      drv_c,
  input  wire logic [7:0]  rom_addr,
  // bench side
  input  wire logic [11:0] ext_val,
  // pin levels and sources
  output logic [11:0]      pins,
  output logic [7:0]       rom_word,
  output logic             gen_a = 1'b0,
  output logic             bclk = 1'b0
);
  logic [11:0] oe;
  logic [3:0]  cnt_r = 4'h0;
  assign oe = {drv_c.oe, drv_b.oe, drv_a.oe};
  // the unit wins where it drives, the outside world drives the rest
  assign pins = (oe & {drv_c.out, drv_b.out, drv_a.out}) | (~oe & ext_val);
  // scrambled image so a wrong index cannot pass
  assign rom_word = {rom_addr[3:0], rom_addr[7:4]} ^ 8'h3c;
  always @(posedge clock) begin
    cnt_r <= cnt_r + 4'h1;
    gen_a <= cnt_r[1];
    bclk  <= cnt_r[3];
  end
endmodule // pin_partner

// ===== tone_pump_gen.sv
// tone_pump_gen: prescaler chain, buzzer carrier/envelope and el pump waveforms
// assumes operands come from the instruction unit on the same clock
`timescale 1ns/1ns
module tone_pump_gen
  import io_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // operands
  input  wire logic [8:0] tone_x,
  input  wire logic [8:0] el_x,
  // sources
  input  wire logic       gen_out_a,
  input  wire logic       bclk_in,
  // outputs
  output logic            buzzer_out,
  output logic            buzzer_out_inv,
  output logic            el_pump_pin,
  output logic            el_control
);
  logic [11:0] div_r;
  logic [15:0] pre_r;
  logic [2:0]  bsync_r;
  logic [2:0]  bdiv_r;
  logic [1:0]  pcnt_r, dcnt_r;
  logic        psrc_d, dsrc_d;
  logic        carrier, env, psrc, dsrc;

  // on-window of a duty setting: period 4,3,2,1 by sel 0..3
  function automatic logic duty_on(input logic [1:0] cnt, input logic [1:0] sel,
                                   input logic pump);
    logic [1:0] k;
    k = (pump && sel != 2'd3) ? 2'(3 - sel) : 2'd1;
    return cnt < k;
  endfunction

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 12'h000;
      pre_r <= 16'h0000;
    end else if (div_r == 12'(PRE_CYC - 1)) begin
      div_r <= 12'h000;
      pre_r <= pre_r + 16'h0001;
    end else begin
      div_r <= div_r + 12'h001;
    end
  end

  always_comb begin
    case (tone_x[8:6])
      3'b111:  carrier = gen_out_a;
      3'b100:  carrier = 1'b1;
      3'b011:  carrier = pre_r[3];
      3'b010:  carrier = pre_r[4];
      3'b001:  carrier = pre_r[5];
      default: carrier = 1'b0;
    endcase
    env = |(tone_x[5:0] & pre_r[15:10]);
    case (el_x[8:6])
      3'b000:  psrc = pre_r[0];
      3'b100:  psrc = bsync_r[1];
      3'b101:  psrc = bdiv_r[0];
      3'b110:  psrc = bdiv_r[1];
      3'b111:  psrc = bdiv_r[2];
      default: psrc = 1'b0;
    endcase
    dsrc = pre_r[4'(8 - el_x[3:2])];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      buzzer_out     <= 1'b0;
      buzzer_out_inv <= 1'b1;
    end else begin
      // with no envelope bit set the carrier passes unmodulated
      buzzer_out     <= carrier & (env | ~|tone_x[5:0]);
      buzzer_out_inv <= ~(carrier & (env | ~|tone_x[5:0]));
    end
  end

  // bclk is a foreign pin: two flops before edge logic reads it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bsync_r <= 3'b000;
      bdiv_r  <= 3'b000;
    end else begin
      bsync_r <= {bsync_r[1:0], bclk_in};
      if (bsync_r[1] && !bsync_r[2]) bdiv_r <= bdiv_r + 3'b001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      psrc_d <= 1'b0;
      dsrc_d <= 1'b0;
      pcnt_r <= 2'd0;
      dcnt_r <= 2'd0;
      el_pump_pin <= 1'b0;
      el_control  <= 1'b0;
    end else begin
      psrc_d <= psrc;
      dsrc_d <= dsrc;
      if (psrc && !psrc_d) pcnt_r <= (pcnt_r >= 2'(3 - el_x[5:4])) ? 2'd0 : pcnt_r + 2'd1;
      if (dsrc && !dsrc_d) dcnt_r <= (dcnt_r >= 2'(3 - el_x[1:0])) ? 2'd0 : dcnt_r + 2'd1;
      el_pump_pin <= psrc & duty_on(pcnt_r, el_x[5:4], 1'b1);
      el_control  <= dsrc & duty_on(dcnt_r, el_x[1:0], 1'b0);
    end
  end

  a_buzz_pair: assert property (@(posedge clock) disable iff (!rst_n)
    buzzer_out != buzzer_out_inv) else $error("buzzer pins not complementary");
  a_buzz_low: assert property (@(posedge clock) disable iff (!rst_n)
    (tone_x[8:6] == 3'b101)[*2] |-> !buzzer_out) else $error("unlisted carrier not low");
  a_pump_off: assert property (@(posedge clock) disable iff (!rst_n)
    (el_x[8:6] == 3'b010)[*2] |-> !el_pump_pin) else $error("unlisted pump clock active");
endmodule // tone_pump_gen
